// *** bst_pkg.sv ***
package bst_pkg;

  // Test logic widths
  localparam int unsigned IR_W    = 3;
  localparam int unsigned ID_W    = 32;
  localparam int unsigned IN_W    = 8;
  localparam int unsigned OUT_W   = 8;
  localparam int unsigned BSR_LEN = IN_W + OUT_W + 1;

  // Boundary register cell positions, lsb nearest the data-out pin
  localparam int unsigned BSR_OE_POS  = 0;
  localparam int unsigned BSR_OUT_LSB = 1;
  localparam int unsigned BSR_IN_LSB  = BSR_OUT_LSB + OUT_W;

  // Identification code fields
  localparam int unsigned ID_MFR_LSB = 1;
  localparam int unsigned ID_DEV_LSB = 12;
  localparam int unsigned ID_VER_LSB = 28;
  // Arbitrary identity values
  localparam logic [10:0] ID_MFR_DEF = 11'h7f;
  localparam logic [15:0] ID_DEV_DEF = 16'h0001;
  localparam logic [3:0]  ID_VER_DEF = 4'h0;

  // Default opcodes
  localparam logic [IR_W-1:0] OP_EXTEST_DEF = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE_DEF = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE_DEF = 3'h2;
  localparam logic [IR_W-1:0] OP_CLAMP_DEF  = 3'h3;
  localparam logic [IR_W-1:0] OP_HIGHZ_DEF  = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS_DEF = 3'h7;

  // Fixed value loaded in capture-IR
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // Reset values
  localparam logic [BSR_LEN-1:0] BSR_RST = '0;
  localparam logic [ID_W-1:0]    ID_RST  = '0;

  typedef enum logic [3:0] {
    ST_TLR   = 4'b1111,
    ST_RTI   = 4'b1100,
    ST_SELDR = 4'b0111,
    ST_CAPDR = 4'b0110,
    ST_SHDR  = 4'b0010,
    ST_EX1DR = 4'b0001,
    ST_PDR   = 4'b0011,
    ST_EX2DR = 4'b0000,
    ST_UPDR  = 4'b0101,
    ST_SELIR = 4'b0100,
    ST_CAPIR = 4'b1110,
    ST_SHIR  = 4'b1010,
    ST_EX1IR = 4'b1001,
    ST_PIR   = 4'b1011,
    ST_EX2IR = 4'b1000,
    ST_UPIR  = 4'b1101
  } bst_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_EXTEST = 2'b01,
    MODE_CLAMP  = 2'b10,
    MODE_HIGHZ  = 2'b11
  } bst_mode_t;

  typedef struct packed {
    logic [OUT_W-1:0] data;
    logic [OUT_W-1:0] oe;
  } bst_pins_t;

  typedef struct packed {
    bst_mode_t         mode;
    logic [OUT_W-1:0]  data;
    logic              oe;
  } bst_xfer_t;

endpackage

// *** bst_tap_fsm.sv ***
`timescale 1ns/1ps
`default_nettype none
module bst_tap_fsm (
  // Test clock and reset
  input  wire logic              tck,
  input  wire logic              trst_n,
  // Mode select
  input  wire logic              tms,
  // Controller state
  output bst_pkg::bst_state_t    state
);
  import bst_pkg::*;

  typedef struct packed {
    bst_state_t state;
  } bst_fsm_t;

  bst_fsm_t cur;
  bst_fsm_t next_cur;

  assign state = cur.state;

  always_comb begin
    next_cur = cur;
    case (cur.state)
      ST_TLR:   next_cur.state = tms ? ST_TLR   : ST_RTI;    // [R24]
      ST_RTI:   next_cur.state = tms ? ST_SELDR : ST_RTI;    // [R24]
      ST_SELDR: next_cur.state = tms ? ST_SELIR : ST_CAPDR;  // [R3]
      ST_CAPDR: next_cur.state = tms ? ST_EX1DR : ST_SHDR;   // [R4]
      ST_SHDR:  next_cur.state = tms ? ST_EX1DR : ST_SHDR;   // [R5]
      ST_EX1DR: next_cur.state = tms ? ST_UPDR  : ST_PDR;    // [R6]
      ST_PDR:   next_cur.state = tms ? ST_EX2DR : ST_PDR;    // [R7]
      ST_EX2DR: next_cur.state = tms ? ST_UPDR  : ST_SHDR;   // [R8]
      ST_UPDR:  next_cur.state = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: next_cur.state = tms ? ST_TLR   : ST_CAPIR;  // [R10]
      ST_CAPIR: next_cur.state = tms ? ST_EX1IR : ST_SHIR;   // [R11]
      ST_SHIR:  next_cur.state = tms ? ST_EX1IR : ST_SHIR;   // [R12]
      ST_EX1IR: next_cur.state = tms ? ST_UPIR  : ST_PIR;    // [R13]
      ST_PIR:   next_cur.state = tms ? ST_EX2IR : ST_PIR;    // [R14]
      ST_EX2IR: next_cur.state = tms ? ST_UPIR  : ST_SHIR;   // [R14]
      ST_UPIR:  next_cur.state = tms ? ST_SELDR : ST_RTI;    // [R15]
      default:  next_cur.state = ST_TLR;
    endcase
  end

  // Advances on the rising test clock edge
  always_ff @(posedge tck or negedge trst_n) begin  // [R1]
    if (!trst_n) begin
      cur.state <= ST_TLR;  // [R25]
    end else begin
      cur <= next_cur;
    end
  end

endmodule
`default_nettype wire

// *** bst_tap_top.sv ***
// Summary of operation
// [R1] TAP state advances on each rising test clock edge, steered by mode select.
// [R2] After power-up: test-logic-reset, IDCODE current, system pins behave normally.
// [R3] Select-DR-scan goes to capture-DR on low, select-IR-scan on high; registers hold.
// [R4] Capture-DR parallel-loads the selected register if allowed; then shift-DR or exit1-DR.
// [R5] Shift-DR moves the selected register one stage toward data-out; others hold.
// [R6] Exit1-DR goes to update-DR on high, pause-DR on low.
// [R7] Pause-DR holds registers; stays while low, exit2-DR on high.
// [R8] Exit2-DR goes to update-DR on high, back to shift-DR on low.
// [R9] Update-DR falling edge copies shift stage into output latches.
// [R10] Select-IR-scan goes to capture-IR on low, test-logic-reset on high.
// [R11] Capture-IR loads a fixed pattern; then exit1-IR on high, shift-IR on low.
// [R12] Shift-IR moves instruction shift stage toward data-out; parallel registers hold.
// [R13] Exit1-IR goes to pause-IR on low, update-IR on high.
// [R14] Pause-IR holds until high; exit2-IR goes update-IR high, shift-IR low.
// [R15] Update-IR falling edge makes shifted code current; then idle or select-DR.
// [R16] Instruction register is a three-bit shift stage plus latched parallel output.
// [R17] SAMPLE/PRELOAD captures pins into boundary register and lets it be shifted.
// [R18] BYPASS routes data-in to data-out through a one-bit register.
// [R19] EXTEST drives output pins from boundary latches; capture samples inputs.
// [R20] CLAMP drives outputs from boundary latches with bypass in the scan path.
// [R21] HIGHZ floats every digital output with bypass in the scan path.
// [R22] IDCODE captures and shifts the identification code; lsb is constant one.
// [R23] Identification register is 32 bits, shift plus latch, selected in reset too.
// [R24] Test-logic-reset holds on high; run-test-idle holds on low.
// [R25] Test reset pin low forces test-logic-reset and IDCODE asynchronously.
// [R26] Opcodes are parameters; unassigned codes act as BYPASS.
`timescale 1ns/1ps
`default_nettype none
module bst_tap_top #(
  parameter logic [bst_pkg::IR_W-1:0] OP_EXTEST = bst_pkg::OP_EXTEST_DEF,
  parameter logic [bst_pkg::IR_W-1:0] OP_IDCODE = bst_pkg::OP_IDCODE_DEF,
  parameter logic [bst_pkg::IR_W-1:0] OP_SAMPLE = bst_pkg::OP_SAMPLE_DEF,
  parameter logic [bst_pkg::IR_W-1:0] OP_CLAMP  = bst_pkg::OP_CLAMP_DEF,
  parameter logic [bst_pkg::IR_W-1:0] OP_HIGHZ  = bst_pkg::OP_HIGHZ_DEF,
  parameter logic [bst_pkg::IR_W-1:0] OP_BYPASS = bst_pkg::OP_BYPASS_DEF,
  // Arbitrary identity values
  parameter logic [10:0]              ID_MFR    = bst_pkg::ID_MFR_DEF,
  parameter logic [15:0]              ID_DEV    = bst_pkg::ID_DEV_DEF,
  parameter logic [3:0]               ID_VER    = bst_pkg::ID_VER_DEF
) (
  // Core clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // Test access port
  input  wire logic                       test_clock_pin,
  input  wire logic                       test_reset_n_pin,
  input  wire logic                       test_mode_select_pin,
  input  wire logic                       test_data_in_pin,
  output logic                            test_data_out_pin,
  output logic                            test_data_out_oe,
  // System side of the digital pins
  input  wire bst_pkg::bst_pins_t         sys_drive,
  input  wire logic [bst_pkg::IN_W-1:0]   pin_in,
  // Digital output pins
  output bst_pkg::bst_pins_t              pin_drive
);
  import bst_pkg::*;

  // Rising test clock state
  typedef struct packed {
    logic [IR_W-1:0]    ir_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [ID_W-1:0]    id_sh;
    logic               byp;
    logic [IN_W-1:0]    in_s1;
    logic [IN_W-1:0]    in_s2;
    bst_pins_t          drv_s1;
    bst_pins_t          drv_s2;
  } bst_tckp_t;

  // Falling test clock state
  typedef struct packed {
    logic [IR_W-1:0]    ir_cur;
    logic [BSR_LEN-1:0] bsr_upd;
    logic [ID_W-1:0]    id_upd;
    logic               tdo;
    logic               tdo_oe;
    logic               tog;
    bst_xfer_t          xfer;
  } bst_tckn_t;

  // Core clock state
  typedef struct packed {
    logic      tog_s1;
    logic      tog_s2;
    logic      tog_seen;
    logic      rst_s1;
    logic      rst_s2;
    bst_xfer_t xfer;
    bst_pins_t drive;
  } bst_core_t;

  bst_tckp_t  tp;
  bst_tckp_t  next_tp;
  bst_tckn_t  tn;
  bst_tckn_t  next_tn;
  bst_core_t  cr;
  bst_core_t  next_cr;
  bst_state_t state;
  logic       tck_rst_n;
  logic       sel_bsr;
  logic       sel_id;
  logic       dr_lsb;
  logic [ID_W-1:0] id_code;

  // Test logic is reset by the pin or by the chip reset
  assign tck_rst_n = test_reset_n_pin & rst_b;

  assign id_code = {ID_VER, ID_DEV, ID_MFR, 1'b1};  // [R22]

  bst_tap_fsm u_fsm (
    .tck    (test_clock_pin),
    .trst_n (tck_rst_n),
    .tms    (test_mode_select_pin),
    .state  (state)
  );

  // Data register selection; unassigned codes fall to bypass
  always_comb begin
    sel_bsr = (tn.ir_cur == OP_EXTEST) || (tn.ir_cur == OP_SAMPLE);  // [R17] [R19]
    sel_id  = (tn.ir_cur == OP_IDCODE);                              // [R22] [R23]
    if (sel_bsr) begin
      dr_lsb = tp.bsr_sh[0];
    end else if (sel_id) begin
      dr_lsb = tp.id_sh[0];
    end else begin
      dr_lsb = tp.byp;  // [R18] [R26]
    end
  end

  // Rising edge: capture and shift
  always_comb begin
    next_tp        = tp;
    // Pins and core values come from other clocks: two stages before capture
    next_tp.in_s1  = pin_in;
    next_tp.in_s2  = tp.in_s1;
    next_tp.drv_s1 = sys_drive;
    next_tp.drv_s2 = tp.drv_s1;
    case (state)
      ST_CAPDR: begin
        if (sel_bsr) begin
          next_tp.bsr_sh = {tp.in_s2, tp.drv_s2.data, |tp.drv_s2.oe};  // [R4] [R17] [R19]
        end else if (sel_id) begin
          next_tp.id_sh = id_code;  // [R22]
        end else begin
          next_tp.byp = 1'b0;  // [R18]
        end
      end
      ST_SHDR: begin
        if (sel_bsr) begin
          next_tp.bsr_sh = {test_data_in_pin, tp.bsr_sh[BSR_LEN-1:1]};  // [R5] [R17]
        end else if (sel_id) begin
          next_tp.id_sh = {test_data_in_pin, tp.id_sh[ID_W-1:1]};  // [R5] [R22]
        end else begin
          next_tp.byp = test_data_in_pin;  // [R18] [R20] [R21]
        end
      end
      ST_CAPIR: begin
        next_tp.ir_sh = IR_CAPTURE;  // [R11]
      end
      ST_SHIR: begin
        next_tp.ir_sh = {test_data_in_pin, tp.ir_sh[IR_W-1:1]};  // [R12] [R16]
      end
      default: begin
        next_tp.ir_sh = tp.ir_sh;  // [R3] [R7] [R10] [R14]
      end
    endcase
  end

  always_ff @(posedge test_clock_pin or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tp.ir_sh  <= IR_CAPTURE;
      tp.bsr_sh <= BSR_RST;
      tp.id_sh  <= ID_RST;
      tp.byp    <= 1'b0;
      tp.in_s1  <= '0;
      tp.in_s2  <= '0;
      tp.drv_s1 <= '0;
      tp.drv_s2 <= '0;
    end else begin
      tp <= next_tp;
    end
  end

  // Falling edge: update latches, instruction and data-out
  always_comb begin
    next_tn        = tn;
    next_tn.tdo    = 1'b0;
    next_tn.tdo_oe = 1'b0;
    case (state)
      ST_TLR: begin
        next_tn.ir_cur = OP_IDCODE;  // [R2] [R23]
      end
      ST_UPIR: begin
        next_tn.ir_cur = tp.ir_sh;  // [R15] [R16]
      end
      // Only update-DR moves the latches, so shifting never reaches the pins
      ST_UPDR: begin
        if (sel_bsr) begin
          next_tn.bsr_upd = tp.bsr_sh;  // [R9]
        end else if (sel_id) begin
          next_tn.id_upd = tp.id_sh;  // [R9] [R23]
        end else begin
          next_tn.bsr_upd = tn.bsr_upd;  // [R20]
        end
      end
      ST_SHDR: begin
        // Launched on the falling edge so it is settled at the next rising edge
        next_tn.tdo    = dr_lsb;  // [R5]
        next_tn.tdo_oe = 1'b1;
      end
      ST_SHIR: begin
        next_tn.tdo    = tp.ir_sh[0];  // [R12]
        next_tn.tdo_oe = 1'b1;
      end
      default: begin
        next_tn.tdo = 1'b0;
      end
    endcase
    // Word handed to the core domain, flagged by a toggle
    if (next_tn.ir_cur == OP_EXTEST) begin
      next_tn.xfer.mode = MODE_EXTEST;  // [R19]
    end else if (next_tn.ir_cur == OP_CLAMP) begin
      next_tn.xfer.mode = MODE_CLAMP;  // [R20]
    end else if (next_tn.ir_cur == OP_HIGHZ) begin
      next_tn.xfer.mode = MODE_HIGHZ;  // [R21]
    end else begin
      next_tn.xfer.mode = MODE_NORMAL;  // [R2] [R17] [R18]
    end
    next_tn.xfer.data = next_tn.bsr_upd[BSR_OUT_LSB +: OUT_W];
    next_tn.xfer.oe   = next_tn.bsr_upd[BSR_OE_POS];
    if (next_tn.xfer != tn.xfer) begin
      next_tn.tog = ~tn.tog;
    end
  end

  always_ff @(negedge test_clock_pin or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tn.ir_cur    <= OP_IDCODE;  // [R25]
      tn.bsr_upd   <= BSR_RST;
      tn.id_upd    <= ID_RST;
      tn.tdo       <= 1'b0;
      tn.tdo_oe    <= 1'b0;
      tn.tog       <= 1'b0;
      tn.xfer.mode <= MODE_NORMAL;
      tn.xfer.data <= '0;
      tn.xfer.oe   <= 1'b0;
    end else begin
      tn <= next_tn;
    end
  end

  assign test_data_out_pin = tn.tdo;
  assign test_data_out_oe  = tn.tdo_oe;

  // Core domain: take the handed-over word and drive the pins
  // The word must hold until its toggle is seen: test clock period at least four core clock periods
  always_comb begin
    next_cr          = cr;
    next_cr.tog_s1   = tn.tog;
    next_cr.tog_s2   = cr.tog_s1;
    next_cr.tog_seen = cr.tog_s2;
    next_cr.rst_s1   = tck_rst_n;
    next_cr.rst_s2   = cr.rst_s1;
    if (!cr.rst_s2) begin
      next_cr.xfer.mode = MODE_NORMAL;  // [R2] [R25]
    end else if (cr.tog_s2 != cr.tog_seen) begin
      next_cr.xfer = tn.xfer;  // [R15]
    end
    case (cr.xfer.mode)
      MODE_EXTEST, MODE_CLAMP: begin
        next_cr.drive.data = cr.xfer.data;                 // [R19] [R20]
        next_cr.drive.oe   = {OUT_W{cr.xfer.oe}};          // [R19] [R20]
      end
      MODE_HIGHZ: begin
        next_cr.drive.data = sys_drive.data;
        next_cr.drive.oe   = '0;  // [R21]
      end
      default: begin
        next_cr.drive = sys_drive;  // [R2] [R17] [R18]
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cr.tog_s1    <= 1'b0;
      cr.tog_s2    <= 1'b0;
      cr.tog_seen  <= 1'b0;
      cr.rst_s1    <= 1'b0;
      cr.rst_s2    <= 1'b0;
      cr.xfer.mode <= MODE_NORMAL;
      cr.xfer.data <= '0;
      cr.xfer.oe   <= 1'b0;
      cr.drive     <= '0;
    end else begin
      cr <= next_cr;
    end
  end

  assign pin_drive = cr.drive;

endmodule
`default_nettype wire

// *** bst_tap_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module bst_tap_properties (
  // Clocks and resets
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  input wire logic                      test_clock_pin,
  input wire logic                      test_reset_n_pin,
  // Test access port
  input wire logic                      test_mode_select_pin,
  input wire logic                      test_data_in_pin,
  input wire logic                      test_data_out_pin,
  input wire logic                      test_data_out_oe,
  // Pins
  input wire bst_pkg::bst_pins_t        sys_drive,
  input wire logic [bst_pkg::IN_W-1:0]  pin_in,
  input wire bst_pkg::bst_pins_t        pin_drive
);
  import bst_pkg::*;
  wire logic tck    = test_clock_pin;
  wire logic tms    = test_mode_select_pin;
  wire logic oe     = test_data_out_oe;
  wire logic dout   = test_data_out_pin;
  wire logic trst_b = test_reset_n_pin && rst_b;

  AST_LEAVE_SHIFT: assert property (@(posedge tck) disable iff (!trst_b) tms |=> !oe)
    else $error("data-out enabled after a mode-select high edge");
  AST_QUIET_DOUT: assert property (@(posedge tck) disable iff (!trst_b) !oe |-> !dout)
    else $error("data-out not low while released");
  AST_SHIFT_ENTRY: assert property (@(posedge tck) disable iff (!trst_b) $rose(oe) |-> !$past(tms))
    else $error("shift entered without mode-select low");
  AST_TLR_HOLD: assert property (@(posedge tck) disable iff (!trst_b)
    tms [*5] ##1 !tms [*2] ##1 tms [*2] ##1 !tms |=> !oe)
    else $error("idle or capture-IR walk went astray");
  AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (!trst_b)
    tms [*5] ##1 !tms [*2] ##1 tms [*2] ##1 !tms [*2] |=> oe && dout ##1 !tms |=> !dout)
    else $error("instruction capture pattern wrong");
  AST_ID_LSB: assert property (@(posedge tck) disable iff (!trst_b)
    tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> oe && dout)
    else $error("identification lsb not one after reset");
  AST_RESET_FORCE: assert property (@(posedge core_clk) disable iff (!rst_b)
    !test_reset_n_pin |-> !oe && !dout)
    else $error("data-out active during test reset");
  AST_NORMAL_PINS: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!test_reset_n_pin) [*8] |=> pin_drive == $past(sys_drive))
    else $error("pins do not follow core logic in test reset");

  cover property (@(posedge tck) disable iff (!trst_b) $rose(oe));
  cover property (@(posedge core_clk) disable iff (!rst_b) $fell(test_reset_n_pin));
  cover property (@(posedge core_clk) disable iff (!rst_b) pin_drive.oe == 8'h00 && sys_drive.oe != 8'h00);
endmodule

bind bst_tap_top bst_tap_properties i_props (
  .core_clk(core_clk), .rst_b(rst_b), .test_clock_pin(test_clock_pin), .test_reset_n_pin(test_reset_n_pin),
  .test_mode_select_pin(test_mode_select_pin), .test_data_in_pin(test_data_in_pin),
  .test_data_out_pin(test_data_out_pin), .test_data_out_oe(test_data_out_oe),
  .sys_drive(sys_drive), .pin_in(pin_in), .pin_drive(pin_drive));
`default_nettype wire

// *** bst_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
  // Driven test lines
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // Returned data line
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last = 1'b0;
  logic line;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // No pull on data-out: a released line shows the inverse of its last level
  always_comb line = tdo_oe ? tdo : ~last;
  always @(posedge tck) if (tdo_oe) last <= tdo;
  // One test clock period; the clock rests low between frames
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #24;
    q = line;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bst_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic test_rst_b = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe;
  bst_pins_t sys_drive = '0;
  bst_pins_t pin_drive;
  logic [IN_W-1:0] pin_in = '0;
  logic [31:0] seed = 32'hbffa;
  logic [63:0] q;
  logic [16:0] p;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #5 core_clk = ~core_clk;

  bst_tap_top i_bst_tap_top (.core_clk(core_clk), .rst_b(rst_b), .test_clock_pin(tck),
    .test_reset_n_pin(test_rst_b), .test_mode_select_pin(tms), .test_data_in_pin(tdi),
    .test_data_out_pin(tdo), .test_data_out_oe(tdo_oe), .sys_drive(sys_drive), .pin_in(pin_in),
    .pin_drive(pin_drive));
  bst_ctl_model i_bst_ctl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [16:0] exp_cap();
    return {pin_in, sys_drive.data, |sys_drive.oe};
  endfunction
  function automatic bst_pins_t drv(input logic [16:0] b);
    return '{data: b[8:1], oe: {8{b[0]}}};
  endfunction

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input bst_pins_t e);
    chk_val(nm, 64'(e), 64'(pin_drive));
  endtask

  // New random core outputs and input pins, then let them settle at the pins
  task automatic draw();
    @(posedge core_clk);
    seed = lfsr(seed);
    sys_drive <= bst_pins_t'(seed[15:0]);
    pin_in <= seed[23:16];
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  task automatic walk(input logic [7:0] m, input int k);
    logic b;
    for (int i = 0; i < k; i++) i_bst_ctl_model.step(m[i], 1'b0, b);
  endtask
  task automatic ir(input logic [2:0] op);
    logic [2:0] cap;
    walk(8'b0011, 4);
    for (int i = 0; i < 3; i++) i_bst_ctl_model.step(i == 2, op[i], cap[i]);
    walk(8'b01, 2);
    chk_val("ir capture", 64'(IR_CAPTURE), 64'(cap));
  endtask
  // Data scan from idle; pz names the bit after which a pause is taken
  task automatic dr(input int n, input int pz, input logic [63:0] din, output logic [63:0] dq);
    dq = '0;
    walk(8'b001, 3);
    for (int i = 0; i < n; i++) begin
      i_bst_ctl_model.step(i == n - 1 || i == pz, din[i], dq[i]);
      if (i == pz) walk(8'b0100, 4);
    end
    walk(8'b01, 2);
  endtask
  task automatic id_check();
    walk(8'b011111, 6);
    dr(32, 10, 64'(lfsr(seed)), q);
    chk_val("idcode", 64'({ID_VER_DEF, ID_DEV_DEF, ID_MFR_DEF, 1'b1}), 64'(q[31:0]));
  endtask
  task automatic byp_check();
    logic [7:0] d;
    d = 8'(lfsr(seed) >> 3);
    dr(8, -1, 64'(d), q);
    chk_val("bypass path", 64'(d[6:0]), 64'(q[7:1]));
    chk_val("bypass capture", 64'h0, 64'(q[0]));
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    test_rst_b <= 1'b1;
    draw();
    chk_pin("normal pins", sys_drive);
    id_check();
    ir(OP_SAMPLE_DEF);
    p = 17'(lfsr(seed) >> 7);
    dr(17, -1, 64'(p), q);
    chk_val("sample capture", 64'(exp_cap()), 64'(q[16:0]));
    ir(OP_EXTEST_DEF);
    draw();
    chk_pin("extest preload", drv(p));
    p = 17'(lfsr(seed) >> 2);
    dr(17, 8, 64'(p), q);
    chk_val("extest capture", 64'(pin_in), 64'(q[16:9]));
    draw();
    chk_pin("extest update", drv(p));
    ir(OP_CLAMP_DEF);
    byp_check();
    draw();
    chk_pin("clamp pins", drv(p));
    for (int c = 7; c > 3; c--) begin
      ir(3'(c));
      byp_check();
      draw();
      if (3'(c) == OP_HIGHZ_DEF) chk_val("highz enables", 64'h0, 64'(pin_drive.oe));
      else chk_pin("bypass pins", sys_drive);
    end
    @(posedge core_clk);
    test_rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    test_rst_b <= 1'b1;
    draw();
    chk_pin("test reset pins", sys_drive);
    id_check();
    walk(8'b0011111, 7);
    ir(OP_SAMPLE_DEF);
    finish_test();
  end
endmodule
`default_nettype wire
